// File: src/ssh_defines.svh
// constants for the serial-port handover and service status block
`ifndef SSH_DEFINES_SVH
`define SSH_DEFINES_SVH
`define SSH_ST_OK            8'h00
`define SSH_ST_HASH          8'h01
`define SSH_ST_EXTRA_DATA    8'h02
`define SSH_ST_BAD_KEY       8'h03
`define SSH_ST_BAD_COMP      8'h04
`define SSH_ST_BACK_LEVEL    8'h05
`define SSH_ST_MODE_OFF      8'h06
`define SSH_ST_SERIAL_BIND   8'h07
`define SSH_ST_SEQUENCE      8'h08
`define SSH_ST_CAPS          8'h09
`define SSH_ST_PART_ID       8'h0A
`define SSH_ST_PROTOCOL      8'h0B
`define SSH_ST_VERIFY_DENY   8'h0C
`define SSH_ST_CERT          8'h0D
`define SSH_ST_INTEGRITY     8'h0E
`define SSH_ST_NOT_MASTER    8'h15
`define SSH_ST_AU_NO_IMG     8'h16
`define SSH_ST_IAP_NO_IMG    8'h17
`define SSH_ST_AU_LATEST     8'h18
`define SSH_ST_RESERVED      8'h19
`define SSH_ST_SEL_INVALID   8'h1A
`define SSH_ST_RECOVERY_FAIL 8'h1B
`define SSH_ST_ABORT         8'h7F
`define SSH_ST_SEG_VERIFY    8'h80
`define SSH_ST_PROTECTED     8'h81
`define SSH_ST_PROG_DISABLED 8'h82
`define SSH_ST_SNV_VERIFY    8'h83
`define SSH_ST_SYSTEM        8'h84
`define SSH_ST_PAYLOAD       8'h85
`define SSH_ST_HV_FAIL       8'h86
`define SSH_ST_HV_STATE      8'h87
`define SSH_FAULT_W          27
`endif

// File: src/ssh_handover.sv
// serial-port ownership arbiter and service completion status
//
// Contract
// - after power-up, hand master port to fabric
// - jtag programming or service request reclaims port
// - controller services use dedicated serial pins only
// - completion returns zero or 8-bit error
// - codes 1 to 4 for image faults
// - codes 5 to 7 for policy faults
// - image not ending cleanly gives code 8
// - codes 9 to 11 for target mismatches
// - codes 12 to 14 for verify/certificate faults
// - code 21 when update without master mode; loaded at request with no done pulse, then overwritten at completion
// - codes 22, 23 for missing image pointers
// - code 24 latest design; 25 never produced
// - codes 26, 27 for recovery outcomes
// - code 127 aborts on foreign instruction mid-image
// - codes 128 to 130 for memory faults
// - codes 131, 132 for secure/hardware faults
// - codes 133 to 135 for payload/high-voltage
`timescale 1ns/100ps
`include "ssh_defines.svh"
module ssh_handover (
    input  wire logic                CORE_CLK,
    input  wire logic                RST,
    input  wire logic                SPI_ENABLE,
    input  wire logic                SPI_MASTER_MODE,
    input  wire logic                JTAG_PROG_START,
    input  wire logic                JTAG_PROG_DONE,
    input  wire logic                SVC_REQ,
    input  wire logic                SVC_IS_UPDATE,
    input  wire logic                CORE_DONE,
    input  wire logic                CORE_IMAGE_ACTIVE,
    input  wire logic                CORE_FOREIGN_INSTR,
    input  wire logic                CORE_PARSE_END_OK,
    input  wire logic [26:0]         CORE_FAULT,
    input  wire logic                CORE_SCK,
    input  wire logic                CORE_MOSI,
    input  wire logic                CORE_CS_N,
    input  wire logic                CORE_DRIVE,
    input  wire logic                FAB_SCK,
    input  wire logic                FAB_MOSI,
    input  wire logic                FAB_CS_N,
    input  wire logic                FLASH_MISO,
    output logic                     FAB_GRANT,
    output logic                     FAB_ABANDON,
    output logic                     FAB_MISO,
    output logic                     CORE_MISO,
    output logic                     CORE_START,
    output logic                     FLASH_SCK,
    output logic                     FLASH_MOSI,
    output logic                     FLASH_CS_N,
    output logic                     FLASH_OE_N,
    output logic                     SVC_DONE,
    output logic [7:0]               SVC_STATUS
);

////////////////////////////////////////////////////////////////////////////////
    ssh_pkg::ssh_owner_e owner_reg;
    ssh_pkg::ssh_svc_e   svc_reg;
    logic                boot_reg;
    logic                port_ok;
    logic                reclaim;
    logic                done_clean;
    logic                done_parsed;
    ssh_status_if        st ();

    assign port_ok = SPI_ENABLE && SPI_MASTER_MODE;
    assign reclaim = JTAG_PROG_START || SVC_REQ;

    // boot hold: controller keeps the port for the first cycle after reset
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) boot_reg <= 1'b1;
        else     boot_reg <= 1'b0;
    end

////////////////////////////////////////////////////////////////////////////////
    // ownership; reclaim has priority over the release to fabric
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            owner_reg <= ssh_pkg::SSH_OWN_CTRL;
        end else begin
            case (owner_reg)
                ssh_pkg::SSH_OWN_CTRL: begin
                    if (JTAG_PROG_START)
                        owner_reg <= ssh_pkg::SSH_OWN_JTAG;
                    else if (!reclaim && svc_reg == ssh_pkg::SSH_IDLE && port_ok && !boot_reg)
                        owner_reg <= ssh_pkg::SSH_OWN_FABRIC;
                end
                ssh_pkg::SSH_OWN_FABRIC: begin
                    if (JTAG_PROG_START)
                        owner_reg <= ssh_pkg::SSH_OWN_JTAG;
                    else if (SVC_REQ || !port_ok)
                        owner_reg <= ssh_pkg::SSH_OWN_CTRL;
                end
                ssh_pkg::SSH_OWN_JTAG: begin
                    if (JTAG_PROG_DONE)
                        owner_reg <= ssh_pkg::SSH_OWN_CTRL;
                end
                default: owner_reg <= ssh_pkg::SSH_OWN_CTRL;
            endcase
        end
    end

    // fabric told to drop its transfer the cycle its grant falls
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            FAB_GRANT   <= 1'b0;
            FAB_ABANDON <= 1'b0;
        end else begin
            FAB_GRANT   <= (owner_reg == ssh_pkg::SSH_OWN_FABRIC) && !reclaim && port_ok;
            FAB_ABANDON <= FAB_GRANT && (reclaim || !port_ok);
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // pin mux: controller reaches flash only through these dedicated pins
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            FLASH_SCK  <= 1'b0;
            FLASH_MOSI <= 1'b0;
            FLASH_CS_N <= 1'b1;
            FLASH_OE_N <= 1'b1;
            FAB_MISO   <= 1'b0;
            CORE_MISO  <= 1'b0;
        end else if (!SPI_ENABLE) begin
            FLASH_OE_N <= 1'b1;
            FLASH_CS_N <= 1'b1;
        end else if (owner_reg == ssh_pkg::SSH_OWN_FABRIC && !reclaim) begin
            FLASH_SCK  <= FAB_SCK;
            FLASH_MOSI <= FAB_MOSI;
            FLASH_CS_N <= FAB_CS_N;
            FLASH_OE_N <= 1'b0;
            FAB_MISO   <= FLASH_MISO;
        end else begin
            FLASH_SCK  <= CORE_SCK;
            FLASH_MOSI <= CORE_MOSI;
            FLASH_CS_N <= CORE_CS_N;
            FLASH_OE_N <= !CORE_DRIVE;
            CORE_MISO  <= FLASH_MISO;
            FAB_MISO   <= 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // service sequence
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            svc_reg    <= ssh_pkg::SSH_IDLE;
            CORE_START <= 1'b0;
        end else begin
            CORE_START <= 1'b0;
            case (svc_reg)
                ssh_pkg::SSH_IDLE: begin
                    if (SVC_REQ && owner_reg != ssh_pkg::SSH_OWN_JTAG) begin
                        svc_reg    <= ssh_pkg::SSH_BUSY;
                        CORE_START <= 1'b1;
                    end
                end
                ssh_pkg::SSH_BUSY: begin
                    if (CORE_DONE || (CORE_IMAGE_ACTIVE && CORE_FOREIGN_INSTR))
                        svc_reg <= ssh_pkg::SSH_DONE;
                end
                ssh_pkg::SSH_DONE: svc_reg <= ssh_pkg::SSH_IDLE;
                default: svc_reg <= ssh_pkg::SSH_IDLE;
            endcase
        end
    end

    assign st.fault        = CORE_FAULT;
    assign st.parse_end_ok = CORE_PARSE_END_OK;

    ssh_status_enc u_enc (
        .st (st)
    );

    // status capture; update request without master mode loads code 21 at once, with no done pulse, and the service still starts
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            SVC_DONE   <= 1'b0;
            SVC_STATUS <= `SSH_ST_OK;
        end else begin
            SVC_DONE <= 1'b0;
            if (svc_reg == ssh_pkg::SSH_BUSY && CORE_IMAGE_ACTIVE && CORE_FOREIGN_INSTR) begin
                SVC_DONE   <= 1'b1;
                SVC_STATUS <= `SSH_ST_ABORT;
            end else if (svc_reg == ssh_pkg::SSH_BUSY && CORE_DONE) begin
                SVC_DONE   <= 1'b1;
                SVC_STATUS <= st.code;
            end else if (svc_reg == ssh_pkg::SSH_IDLE && SVC_REQ && SVC_IS_UPDATE
                         && !SPI_MASTER_MODE) begin
                SVC_STATUS <= `SSH_ST_NOT_MASTER;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    owner_release_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        owner_reg == ssh_pkg::SSH_OWN_CTRL && port_ok && !reclaim && !boot_reg
        && svc_reg == ssh_pkg::SSH_IDLE |=> owner_reg == ssh_pkg::SSH_OWN_FABRIC)
        else $error("port not released to fabric");

    reclaim_port_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        owner_reg == ssh_pkg::SSH_OWN_FABRIC && reclaim |=> owner_reg != ssh_pkg::SSH_OWN_FABRIC)
        else $error("port not reclaimed");

    grant_drop_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        FAB_GRANT && reclaim |=> !FAB_GRANT && FAB_ABANDON)
        else $error("fabric grant not dropped");

    dedicated_pins_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        SPI_ENABLE && owner_reg == ssh_pkg::SSH_OWN_CTRL |=> FLASH_SCK == $past(CORE_SCK))
        else $error("controller clock not on pins");

    abort_code_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        svc_reg == ssh_pkg::SSH_BUSY && CORE_IMAGE_ACTIVE && CORE_FOREIGN_INSTR
        |=> SVC_DONE && SVC_STATUS == `SSH_ST_ABORT)
        else $error("abort code missing");

    success_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        svc_reg == ssh_pkg::SSH_BUSY && CORE_DONE && !CORE_FOREIGN_INSTR && CORE_FAULT == '0
        && CORE_PARSE_END_OK |=> SVC_DONE && SVC_STATUS == `SSH_ST_OK)
        else $error("success not zero");

    sequence_code_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        svc_reg == ssh_pkg::SSH_BUSY && CORE_DONE && !CORE_IMAGE_ACTIVE
        && CORE_FAULT[6:0] == '0 && !CORE_PARSE_END_OK |=> SVC_STATUS == `SSH_ST_SEQUENCE)
        else $error("sequence code wrong");

    reserved_never_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        SVC_DONE |-> SVC_STATUS != `SSH_ST_RESERVED)
        else $error("reserved code produced");

    not_master_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        svc_reg == ssh_pkg::SSH_IDLE && SVC_REQ && SVC_IS_UPDATE && !SPI_MASTER_MODE
        |=> SVC_STATUS == `SSH_ST_NOT_MASTER)
        else $error("not-master code missing");

    done_pulse_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        SVC_DONE |=> !SVC_DONE)
        else $error("done longer than one cycle");

////////////////////////////////////////////////////////////////////////////////
    // completion that no same-cycle abort overrides; parse state ranks after code 7
    assign done_clean  = svc_reg == ssh_pkg::SSH_BUSY && CORE_DONE && !CORE_FOREIGN_INSTR;
    assign done_parsed = done_clean && CORE_PARSE_END_OK;

    hash_code_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_clean && CORE_FAULT[0] |=> SVC_STATUS == `SSH_ST_HASH)
        else $error("hash code wrong");

    extra_data_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_clean && CORE_FAULT[1:0] == 2'h2 |=> SVC_STATUS == `SSH_ST_EXTRA_DATA)
        else $error("extra data code wrong");

    bad_key_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_clean && CORE_FAULT[2:0] == 3'h4 |=> SVC_STATUS == `SSH_ST_BAD_KEY)
        else $error("key code wrong");

    bad_comp_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_clean && CORE_FAULT[3:0] == 4'h8 |=> SVC_STATUS == `SSH_ST_BAD_COMP)
        else $error("component code wrong");

    back_level_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_clean && CORE_FAULT[4:0] == 5'h10 |=> SVC_STATUS == `SSH_ST_BACK_LEVEL)
        else $error("back level code wrong");

    mode_off_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_clean && CORE_FAULT[5:0] == 6'h20 |=> SVC_STATUS == `SSH_ST_MODE_OFF)
        else $error("mode code wrong");

    serial_bind_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_clean && CORE_FAULT[6:0] == 7'h40 |=> SVC_STATUS == `SSH_ST_SERIAL_BIND)
        else $error("serial binding code wrong");

    caps_code_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[7:0] == 8'h80 |=> SVC_STATUS == `SSH_ST_CAPS)
        else $error("capability code wrong");

    part_id_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[8:0] == 9'h100 |=> SVC_STATUS == `SSH_ST_PART_ID)
        else $error("part code wrong");

    protocol_code_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[9:0] == 10'h200 |=> SVC_STATUS == `SSH_ST_PROTOCOL)
        else $error("protocol code wrong");

    verify_deny_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[10:0] == 11'h400 |=> SVC_STATUS == `SSH_ST_VERIFY_DENY)
        else $error("verify code wrong");

    cert_code_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[11:0] == 12'h800 |=> SVC_STATUS == `SSH_ST_CERT)
        else $error("certificate code wrong");

    integrity_code_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[12:0] == 13'h1000 |=> SVC_STATUS == `SSH_ST_INTEGRITY)
        else $error("integrity code wrong");

    master_fault_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[13:0] == 14'h2000 |=> SVC_STATUS == `SSH_ST_NOT_MASTER)
        else $error("master mode code wrong");

    auto_pointer_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[14:0] == 15'h4000 |=> SVC_STATUS == `SSH_ST_AU_NO_IMG)
        else $error("auto pointer code wrong");

    update_pointer_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[15:0] == 16'h8000 |=> SVC_STATUS == `SSH_ST_IAP_NO_IMG)
        else $error("indexed pointer code wrong");

    auto_latest_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[16:0] == 17'h1_0000 |=> SVC_STATUS == `SSH_ST_AU_LATEST)
        else $error("latest code wrong");

    sel_invalid_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[17:0] == 18'h2_0000 |=> SVC_STATUS == `SSH_ST_SEL_INVALID)
        else $error("selected image code wrong");

    recovery_fail_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[18:0] == 19'h4_0000
        |=> SVC_STATUS == `SSH_ST_RECOVERY_FAIL)
        else $error("recovery code wrong");

    seg_verify_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[19:0] == 20'h8_0000 |=> SVC_STATUS == `SSH_ST_SEG_VERIFY)
        else $error("segment verify code wrong");

    protected_code_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[20:0] == 21'h10_0000 |=> SVC_STATUS == `SSH_ST_PROTECTED)
        else $error("protected code wrong");

    prog_disabled_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[21:0] == 22'h20_0000
        |=> SVC_STATUS == `SSH_ST_PROG_DISABLED)
        else $error("disabled mode code wrong");

    snv_verify_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[22:0] == 23'h40_0000 |=> SVC_STATUS == `SSH_ST_SNV_VERIFY)
        else $error("secure verify code wrong");

    system_fault_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[23:0] == 24'h80_0000 |=> SVC_STATUS == `SSH_ST_SYSTEM)
        else $error("system code wrong");

    payload_code_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[24:0] == 25'h100_0000 |=> SVC_STATUS == `SSH_ST_PAYLOAD)
        else $error("payload code wrong");

    hv_fail_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[25:0] == 26'h200_0000 |=> SVC_STATUS == `SSH_ST_HV_FAIL)
        else $error("high voltage code wrong");

    hv_state_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        done_parsed && CORE_FAULT[26:0] == 27'h400_0000 |=> SVC_STATUS == `SSH_ST_HV_STATE)
        else $error("high voltage state code wrong");
endmodule

// File: src/ssh_pkg.sv
// types for the serial-port handover and service status block
package ssh_pkg;
    typedef enum logic [1:0] {SSH_OWN_CTRL, SSH_OWN_FABRIC, SSH_OWN_JTAG} ssh_owner_e;
    typedef enum logic [1:0] {SSH_IDLE, SSH_BUSY, SSH_DONE} ssh_svc_e;
    typedef logic [7:0] ssh_status_t;
endpackage

// File: src/ssh_status_enc.sv
// priority encoder from fault flags to the 8-bit completion status
`timescale 1ns/100ps
`include "ssh_defines.svh"
module ssh_status_enc (
    ssh_status_if.enc st
);
    // lowest flag wins; reserved code 25 has no flag so it never appears
    always_comb begin
        st.code = `SSH_ST_OK;
        if (st.fault[0]) st.code = `SSH_ST_HASH;
        else if (st.fault[1]) st.code = `SSH_ST_EXTRA_DATA;
        else if (st.fault[2]) st.code = `SSH_ST_BAD_KEY;
        else if (st.fault[3]) st.code = `SSH_ST_BAD_COMP;
        else if (st.fault[4]) st.code = `SSH_ST_BACK_LEVEL;
        else if (st.fault[5]) st.code = `SSH_ST_MODE_OFF;
        else if (st.fault[6]) st.code = `SSH_ST_SERIAL_BIND;
        else if (!st.parse_end_ok) st.code = `SSH_ST_SEQUENCE;
        else if (st.fault[7]) st.code = `SSH_ST_CAPS;
        else if (st.fault[8]) st.code = `SSH_ST_PART_ID;
        else if (st.fault[9]) st.code = `SSH_ST_PROTOCOL;
        else if (st.fault[10]) st.code = `SSH_ST_VERIFY_DENY;
        else if (st.fault[11]) st.code = `SSH_ST_CERT;
        else if (st.fault[12]) st.code = `SSH_ST_INTEGRITY;
        else if (st.fault[13]) st.code = `SSH_ST_NOT_MASTER;
        else if (st.fault[14]) st.code = `SSH_ST_AU_NO_IMG;
        else if (st.fault[15]) st.code = `SSH_ST_IAP_NO_IMG;
        else if (st.fault[16]) st.code = `SSH_ST_AU_LATEST;
        else if (st.fault[17]) st.code = `SSH_ST_SEL_INVALID;
        else if (st.fault[18]) st.code = `SSH_ST_RECOVERY_FAIL;
        else if (st.fault[19]) st.code = `SSH_ST_SEG_VERIFY;
        else if (st.fault[20]) st.code = `SSH_ST_PROTECTED;
        else if (st.fault[21]) st.code = `SSH_ST_PROG_DISABLED;
        else if (st.fault[22]) st.code = `SSH_ST_SNV_VERIFY;
        else if (st.fault[23]) st.code = `SSH_ST_SYSTEM;
        else if (st.fault[24]) st.code = `SSH_ST_PAYLOAD;
        else if (st.fault[25]) st.code = `SSH_ST_HV_FAIL;
        else if (st.fault[26]) st.code = `SSH_ST_HV_STATE;
    end
endmodule

// File: src/ssh_status_if.sv
// fault flags from the controller core and the encoded status
`timescale 1ns/100ps
interface ssh_status_if;
    logic [26:0]         fault;
    logic                parse_end_ok;
    ssh_pkg::ssh_status_t code;
    modport enc  (input fault, input parse_end_ok, output code);
    modport core (output fault, output parse_end_ok, input code);
endinterface

// File: tb/service_spi_handover_status_bench.sv
// self-checking bench for the serial-port handover and status block
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module service_spi_handover_status_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        spi_en = 1'b1, master = 1'b1, jtag_start = 1'b0, jtag_done = 1'b0;
    logic        svc_req = 1'b0, svc_upd = 1'b0, core_done = 1'b0, img_act = 1'b0;
    logic        foreign = 1'b0, parse_ok = 1'b1, core_sck = 1'b0, core_mosi = 1'b0;
    logic        core_cs_n = 1'b1, core_drive = 1'b0, flash_miso = 1'b0, fab_run = 1'b0;
    logic [26:0] fault = 27'h000_0000;
    logic        fab_sck, fab_mosi, fab_cs_n, grant, abandon, fab_miso, core_miso, start;
    logic        flash_sck, flash_mosi, flash_cs_n, oe_n, done;
    logic [7:0]  status;
    int          fails = 0;
    int          checked = 0;
    ssh_pkg::ssh_status_t tbl [27] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1A, 8'h1B,
        8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87};
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    ssh_handover u_dut (.CORE_CLK(clk), .RST(rst), .SPI_ENABLE(spi_en), .SPI_MASTER_MODE(master),
        .JTAG_PROG_START(jtag_start), .JTAG_PROG_DONE(jtag_done), .SVC_REQ(svc_req),
        .SVC_IS_UPDATE(svc_upd), .CORE_DONE(core_done), .CORE_IMAGE_ACTIVE(img_act),
        .CORE_FOREIGN_INSTR(foreign), .CORE_PARSE_END_OK(parse_ok), .CORE_FAULT(fault),
        .CORE_SCK(core_sck), .CORE_MOSI(core_mosi), .CORE_CS_N(core_cs_n),
        .CORE_DRIVE(core_drive), .FAB_SCK(fab_sck), .FAB_MOSI(fab_mosi), .FAB_CS_N(fab_cs_n),
        .FLASH_MISO(flash_miso), .FAB_GRANT(grant), .FAB_ABANDON(abandon), .FAB_MISO(fab_miso),
        .CORE_MISO(core_miso), .CORE_START(start), .FLASH_SCK(flash_sck),
        .FLASH_MOSI(flash_mosi), .FLASH_CS_N(flash_cs_n), .FLASH_OE_N(oe_n), .SVC_DONE(done),
        .SVC_STATUS(status));
    ssh_fabric_model u_fab (.clk(clk), .rst(rst), .grant(grant), .abandon(abandon),
        .run(fab_run), .sck(fab_sck), .mosi(fab_mosi), .cs_n(fab_cs_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // sel: 0 start, 1 done, 2 grant, 3 abandon; bounded so a dead output cannot hang
    task automatic wait_on(input int sel);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!((sel == 0 && start === 1'b1) || (sel == 1 && done === 1'b1) ||
                     (sel == 2 && grant === 1'b1) || (sel == 3 && abandon === 1'b1)) && n < 20);
        if (n >= 20) begin
            fails++;
            $display("[ERR] %0t no response on select %0d", $time, sel);
        end
    endtask
    task automatic pulse_req(input logic upd);
        @(posedge clk);
        svc_req <= 1'b1;
        svc_upd <= upd;
        @(posedge clk);
        svc_req <= 1'b0;
    endtask
    task automatic finish_svc(input logic [26:0] f, input logic ok, input logic [7:0] exp);
        @(posedge clk);
        fault     <= f;
        parse_ok  <= ok;
        core_done <= 1'b1;
        @(posedge clk);
        core_done <= 1'b0;
        wait_on(1);
        `CHK(status, exp)
        @(negedge clk);
        `CHK(done, 1'b0)
    endtask
    task automatic svc(input logic [26:0] f, input logic ok, input logic [7:0] exp);
        pulse_req(1'b0);
        wait_on(0);
        finish_svc(f, ok, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_handover();
        logic s;
        logic m;
        wait_on(2);
        @(posedge clk);
        fab_run    <= 1'b1;
        flash_miso <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK(flash_cs_n, 1'b0)
        `CHK(oe_n, 1'b0)
        `CHK(fab_miso, 1'b1)
        s = flash_sck;
        m = fab_mosi;
        @(negedge clk);
        `CHK(flash_sck, ~s)
        `CHK(flash_mosi, m)
        pulse_req(1'b0);
        wait_on(3);
        `CHK(grant, 1'b0)
        repeat (2) @(negedge clk);
        `CHK(fab_cs_n, 1'b1)
        @(posedge clk);
        core_cs_n  <= 1'b0;
        core_drive <= 1'b1;
        core_mosi  <= 1'b1;
        flash_miso <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK(flash_cs_n, 1'b0)
        `CHK(oe_n, 1'b0)
        `CHK(core_miso, 1'b0)
        `CHK(flash_mosi, 1'b1)
        @(posedge clk);
        core_cs_n  <= 1'b1;
        core_drive <= 1'b0;
        core_mosi  <= 1'b0;
        finish_svc(27'h000_0000, 1'b1, 8'h00);
    endtask
    task automatic t_codes();
        for (int i = 0; i < 27; i++) begin
            svc(27'h000_0001 << i, 1'b1, tbl[i]);
        end
        svc(27'h000_0000, 1'b0, 8'h08);
        svc(27'h000_0006, 1'b1, 8'h02);
    endtask
    task automatic t_abort();
        pulse_req(1'b0);
        wait_on(0);
        @(posedge clk);
        img_act <= 1'b1;
        foreign <= 1'b1;
        @(posedge clk);
        foreign <= 1'b0;
        wait_on(1);
        `CHK(status, 8'h7F)
        @(posedge clk);
        img_act <= 1'b0;
    endtask
    task automatic t_not_master();
        @(posedge clk);
        master <= 1'b0;
        pulse_req(1'b1);
        wait_on(0);
        @(negedge clk);
        `CHK(status, 8'h15)
        finish_svc(27'h000_0000, 1'b1, 8'h00);
        @(posedge clk);
        master <= 1'b1;
    endtask
    task automatic t_jtag();
        wait_on(2);
        @(posedge clk);
        jtag_start <= 1'b1;
        @(posedge clk);
        jtag_start <= 1'b0;
        wait_on(3);
        `CHK(grant, 1'b0)
        pulse_req(1'b0);
        repeat (4) begin
            @(negedge clk);
            `CHK(start, 1'b0)
        end
        @(posedge clk);
        jtag_done <= 1'b1;
        @(posedge clk);
        jtag_done <= 1'b0;
        wait_on(2);
        @(posedge clk);
        spi_en <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK(oe_n, 1'b1)
        `CHK(flash_cs_n, 1'b1)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_handover();
        t_codes();
        t_abort();
        t_not_master();
        t_jtag();
        tally_and_finish();
    end
    // the whole sequence needs well under 1000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule

// File: tb/ssh_fabric_model.sv
// fabric user logic that drives the flash once the port is handed over
`timescale 1ns/100ps
module ssh_fabric_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic grant,
    input  wire logic abandon,
    input  wire logic run,
    output logic      sck,
    output logic      mosi,
    output logic      cs_n
);
    logic [7:0] shift_reg;
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_n      <= 1'b1;
            sck       <= 1'b0;
            mosi      <= 1'b0;
            shift_reg <= 8'hA5;
        end else if (!grant || abandon || !run) begin
            // released: clock stands, data keeps changing so no stale bit reads valid
            cs_n <= 1'b1;
            sck  <= 1'b0;
            mosi <= ~mosi;
        end else begin
            cs_n <= 1'b0;
            sck  <= ~sck;
            if (sck) begin
                shift_reg <= {shift_reg[6:0], shift_reg[7]};
                mosi      <= shift_reg[7];
            end
        end
    end
endmodule
